// File: icache_control_policy_bench.sv
`timescale 1ns/1ps
`default_nettype none
module icache_control_policy_bench;
    logic        clk_sys = 1'b0, rst = 1'b1, ctrlWrite, fetchReq, regionHit;
    logic        regionInhib, fetchInhib, bufHit, fillStart, fillInhib;
    logic        fillDone, allocReq, allocDone, pushReq, cacheOn, busStall;
    logic [31:0] ctrlWdata, ctrlRdata, ctl;
    logic [27:0] fetchLine, fillLine, l, bl;
    logic [1:0]  fetchTt, fillTt, allocWay, pushWay;
    logic [7:0]  allocSet, pushSet, lookupSet, s;
    logic [3:0]  wayValid;
    int          failures = 0, num_checks = 0, rr = 0, k;
    bit          v[256][4], bv;
    always #4 clk_sys = ~clk_sys;
    icc_control dut (.clk_sys, .rst, .ctrlWrite, .ctrlWdata, .ctrlRdata,
        .fetchReq, .fetchLine, .fetchTt, .regionHit, .regionInhib,
        .fetchInhib, .bufHit, .fillStart, .fillLine, .fillInhib, .fillTt,
        .fillDone, .allocReq, .allocSet, .allocWay, .allocDone, .pushReq,
        .pushSet, .pushWay, .lookupSet, .wayValid, .cacheOn, .busStall);
    icc_far_model far (.clk_sys, .fillStart, .fillLine, .fillInhib,
        .fillTt, .fillDone);
    // --------
    // shared tasks
    // --------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wctl(logic [31:0] d);
        ctl = d & 32'h0000_bd00;
        @(negedge clk_sys);
        {ctrlWrite, ctrlWdata} = {1'b1, ctl};
        @(negedge clk_sys);
        {ctrlWrite, ctrlWdata} = {1'b0, ~ctl};
        chk("ctrl", ctl, ctrlRdata);
        chk("on", ctl[15], cacheOn);
        if (ctl[8]) begin
            chk("stall", 1, busStall);
            for (k = 0; k < 400 && busStall !== 1'b0; k++) @(negedge clk_sys);
            chk("span", 256, k);
            chk("self clear", ctl & ~32'h100, ctrlRdata);
            v = '{default: '0};
            bv = 1'b0;
        end else begin
            chk("idle", 0, busStall);
        end
    endtask : wctl
    task automatic look(logic [7:0] a);
        @(negedge clk_sys);
        lookupSet = a;
        @(negedge clk_sys);
        chk("valid", {v[a][3], v[a][2], v[a][1], v[a][0]}, wayValid);
    endtask : look
    task automatic fetch(logic [27:0] a, logic [1:0] t, bit rnd);
        logic h, i, e, hit;
        {h, i} = rnd ? 2'($urandom) : 2'h0;
        e = h ? i : ctl[10];
        hit = bv && bl === a && t == 2'h0 && ctl[13] && e;
        @(negedge clk_sys);
        {fetchReq, fetchLine, fetchTt, regionHit, regionInhib} =
            {1'b1, a, t, h, i};
        @(negedge clk_sys);
        {fetchReq, fetchLine} = {1'b0, ~a};
        chk("inhib", e, fetchInhib);
        chk("buf", hit, bufHit);
    endtask : fetch
    task automatic fill(logic [27:0] a, logic i, logic [1:0] t);
        far.burst(a, i, t);
        bv = i && t == 2'h0 && ctl[13];
        bl = a;
    endtask : fill
    task automatic alloc(logic [7:0] a);
        int w;
        w = -1;
        for (int i = 3; i >= 0; i--) begin
            if (!v[a][i] && (!ctl[11] || i > 1)) w = i;
        end
        if (w < 0 && ctl[11]) begin
            w = rr[1] ? 3 : 2;
            rr = rr ^ 2;
        end else if (w < 0) begin
            w = rr;
            rr = (rr + 1) % 4;
        end
        v[a][w] = 1'b1;
        @(negedge clk_sys);
        {allocReq, allocSet} = {1'b1, a};
        @(negedge clk_sys);
        allocReq = 1'b0;
        chk("done", 1, allocDone);
        chk("way", w, allocWay);
    endtask : alloc
    task automatic push(logic [7:0] a, logic [1:0] w);
        @(negedge clk_sys);
        {pushReq, pushSet, pushWay} = {1'b1, a, w};
        @(negedge clk_sys);
        pushReq = 1'b0;
        if (!ctl[12]) v[a][w] = 1'b0;
        look(a);
    endtask : push
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        failures++;
        end_sim();
    end
    // --------
    // tests
    // --------
    initial begin
        {ctrlWrite, ctrlWdata, fetchReq, fetchLine, fetchTt, regionHit,
            regionInhib, allocReq, allocSet, pushReq, pushSet, pushWay,
            lookupSet} = '0;
        void'($urandom(32'hc3b9e6f6));
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        chk("reset", 0, ctrlRdata);
        chk("reset stall", 0, busStall);
        wctl(32'h0000_8100);
        s = 8'($urandom);
        look(s);
        $display("test invalidate done");
        repeat (6) alloc(s);
        wctl(32'h0000_8800);
        repeat (4) alloc(s + 8'h01);
        push(s, 2'h0);
        repeat (3) alloc(s);
        wctl(32'h0000_9800);
        push(s, 2'h1);
        $display("test allocation done");
        wctl(32'h0000_a400);
        l = 28'($urandom);
        fill(l, 1'b1, 2'h0);
        fetch(l, 2'h0, 1'b0);
        fetch(l, 2'h0, 1'b1);
        fetch(l, 2'h2, 1'b0);
        fetch(l + 28'h1, 2'h0, 1'b1);
        fill(l, 1'b1, 2'h1);
        fetch(l, 2'h0, 1'b0);
        fill(l, 1'b1, 2'h0);
        fill(l + 28'h1, 1'b0, 2'h0);
        fetch(l, 2'h0, 1'b0);
        fill(l, 1'b1, 2'h0);
        wctl(32'h0000_8400);
        fetch(l, 2'h0, 1'b0);
        wctl(32'h0000_a500);
        fetch(l, 2'h0, 1'b0);
        wctl(32'h0000_8400);
        fill(l, 1'b1, 2'h0);
        fetch(l, 2'h0, 1'b1);
        alloc(s);
        $display("test fill buffer done");
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        ctl = '0;
        rr = 0;
        bv = 1'b0;
        chk("reset", 0, ctrlRdata);
        chk("reset stall", 0, busStall);
        chk("reset on", 0, cacheOn);
        look(s);
        wctl(32'h0000_8000);
        wctl(32'h0000_0000);
        look(s);
        $display("test reset done");
        end_sim();
    end
endmodule : icache_control_policy_bench
`default_nettype wire

// File: icc_control.sv
`timescale 1ns/1ps
`default_nettype none
module icc_control (
    input  wire logic        clk_sys,      // core clock
    input  wire logic        rst,          // sync reset, high
    input  wire logic        ctrlWrite,    // control word write strobe
    input  wire logic [31:0] ctrlWdata,    // control word write data
    output logic      [31:0] ctrlRdata,    // control word readback
    input  wire logic        fetchReq,     // fetch lookup strobe
    input  wire logic [27:0] fetchLine,    // fetch line address
    input  wire logic [1:0]  fetchTt,      // fetch transfer_type
    input  wire logic        regionHit,    // hit base or access region
    input  wire logic        regionInhib,  // region says inhibited
    output logic             fetchInhib,   // fetch is cache-inhibited
    output logic             bufHit,       // fetch served by fill buffer
    input  wire logic        fillStart,    // burst line fill begins
    input  wire logic [27:0] fillLine,     // line of that fill
    input  wire logic        fillInhib,    // fill is inhibited
    input  wire logic [1:0]  fillTt,       // fill transfer_type
    input  wire logic        fillDone,     // burst line fill ends
    input  wire logic        allocReq,     // allocate a way
    input  wire logic [7:0]  allocSet,     // set to allocate in
    output logic      [1:0]  allocWay,     // chosen way
    output logic             allocDone,    // pulse, way chosen
    input  wire logic        pushReq,      // line push instruction
    input  wire logic [7:0]  pushSet,      // pushed set
    input  wire logic [1:0]  pushWay,      // pushed way
    input  wire logic [7:0]  lookupSet,    // set to report
    output logic      [3:0]  wayValid,     // valid bits of lookupSet
    output logic             cacheOn,      // cache enable
    output logic             busStall      // local bus stall
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                          ctrl;
        logic [icc_pkg::NumSets-1:0][3:0]     valid;
        logic                                 busy;
        logic [icc_pkg::SetBits-1:0]          invSet;
        logic [1:0]                           rr;
        logic                                 fbValid;
        logic [icc_pkg::LineBits-1:0]         fbLine;
        logic                                 fbPend;
        logic [icc_pkg::LineBits-1:0]         pendLine;
        logic [31:0]                          rdata;
        logic                                 inhib;
        logic                                 hit;
        logic [1:0]                           way;
        logic                                 done;
        logic [3:0]                           wv;
    } icc_state_s;

    icc_state_s q;
    icc_state_s next_q;
    logic       inhibNow;
    logic       halfLock;
    logic [3:0] setValid;
    logic [1:0] pick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q   = q;
        halfLock = q.ctrl[icc_pkg::HalfLockBit];                // R10
        inhibNow = regionHit ? regionInhib
                             : q.ctrl[icc_pkg::DefaultModeBit]; // R11
        setValid = q.valid[allocSet];
        pick     = 2'h0;
        next_q.done = 1'b0;
        next_q.hit  = 1'b0;
        if (ctrlWrite) begin
            next_q.ctrl = ctrlWdata;                            // R16
            next_q.ctrl[icc_pkg::InvalidateAllBit] = 1'b0;
            if (ctrlWdata[icc_pkg::InvalidateAllBit]) begin     // R12
                next_q.fbValid = 1'b0;                          // R4
            end
        end
        if (q.busy) begin
            next_q.valid[q.invSet] = 4'h0;                      // R12
            next_q.invSet = q.invSet + 8'h01;
            if (q.invSet == icc_pkg::LastSet) begin
                next_q.busy = 1'b0;                             // R13
            end
        end else begin
            if (fetchReq) begin
                next_q.inhib = inhibNow;
                next_q.hit = inhibNow && q.fbValid
                    && q.ctrl[icc_pkg::FillBufEnableBit]        // R1
                    && fetchTt == icc_pkg::NormalTt
                    && q.fbLine == fetchLine;                   // R3
            end
            if (fillStart) begin
                next_q.fbValid  = 1'b0;                         // R4
                next_q.fbPend   = fillInhib
                    && q.ctrl[icc_pkg::FillBufEnableBit]
                    && fillTt == icc_pkg::NormalTt;             // R2
                next_q.pendLine = fillLine;
            end else if (fillDone && q.fbPend) begin
                next_q.fbValid = 1'b1;                          // R3
                next_q.fbLine  = q.pendLine;                    // R5
                next_q.fbPend  = 1'b0;
            end
            if (pushReq && !q.ctrl[icc_pkg::PushInvDisableBit]) begin
                next_q.valid[pushSet][pushWay] = 1'b0;          // R6
            end
            if (allocReq) begin
                if (!halfLock) begin
                    if (!setValid[0])      pick = 2'h0;         // R7
                    else if (!setValid[1]) pick = 2'h1;
                    else if (!setValid[2]) pick = 2'h2;
                    else if (!setValid[3]) pick = 2'h3;
                    else begin
                        pick      = q.rr;
                        next_q.rr = q.rr + 2'h1;
                    end
                end else begin
                    if (!setValid[2])      pick = 2'h2;         // R8
                    else if (!setValid[3]) pick = 2'h3;
                    else begin
                        pick      = q.rr[1] ? 2'h3 : 2'h2;      // R9
                        next_q.rr = {~q.rr[1], q.rr[0]};
                    end
                end
                next_q.valid[allocSet][pick] = 1'b1;
                next_q.way  = pick;
                next_q.done = 1'b1;
            end
        end
        // an invalidate write, even mid-sweep, restarts at set 0
        if (ctrlWrite && ctrlWdata[icc_pkg::InvalidateAllBit]) begin
            next_q.busy   = 1'b1;                               // R12
            next_q.invSet = '0;
        end
        next_q.rdata = next_q.ctrl;
        next_q.rdata[icc_pkg::InvalidateAllBit] = next_q.busy;  // R19
        next_q.wv = next_q.valid[lookupSet];
        if (rst) begin
            next_q.ctrl    = icc_pkg::CtrlReset;                // R18
            next_q.busy    = 1'b0;
            next_q.invSet  = '0;
            next_q.rr      = 2'h0;
            next_q.fbValid = 1'b0;
            next_q.fbPend  = 1'b0;
            next_q.rdata   = icc_pkg::CtrlReset;
            next_q.inhib   = 1'b0;
            next_q.hit     = 1'b0;
            next_q.way     = 2'h0;
            next_q.done    = 1'b0;
            next_q.valid   = q.valid;                           // R14
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= next_q;
    end

    assign ctrlRdata  = q.rdata;
    assign fetchInhib = q.inhib;
    assign bufHit     = q.hit;
    assign allocWay   = q.way;
    assign allocDone  = q.done;
    assign wayValid   = q.wv;
    assign cacheOn    = q.ctrl[icc_pkg::CacheEnableBit];        // R17
    assign busStall   = q.busy;                                 // R13

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    fb_disabled_a: assert property ( // R1
        bufHit |-> $past(q.ctrl[icc_pkg::FillBufEnableBit]))
        else $error("fill buffer hit while disabled");
    fb_type_a: assert property ( // R2
        bufHit |-> $past(fetchTt) == icc_pkg::NormalTt && $past(inhibNow))
        else $error("fill buffer hit on wrong fetch");
    fb_drop_a: assert property ( // R4
        fillStart && !q.busy |=> !q.fbValid)
        else $error("fill buffer kept across new fill");
    push_inv_a: assert property ( // R6
        pushReq && !q.busy && !allocReq
        && !q.ctrl[icc_pkg::PushInvDisableBit]
        |=> !q.valid[$past(pushSet)][$past(pushWay)])
        else $error("pushed line still valid");
    half_way_a: assert property ( // R9
        allocReq && !q.busy && halfLock |=> allocWay[1])
        else $error("locked way allocated");
    rr_pick_a: assert property ( // R7
        allocReq && !q.busy && !halfLock && &setValid
        |=> allocWay == $past(q.rr) && q.rr == $past(q.rr) + 2'h1)
        else $error("round-robin pick wrong");
    inv_stall_a: assert property ( // R13
        ctrlWrite && ctrlWdata[icc_pkg::InvalidateAllBit] && !q.busy
        |=> busStall [*8])
        else $error("no stall during invalidation");
    inv_read_a: assert property ( // R19
        ctrlRdata[icc_pkg::InvalidateAllBit] == busStall)
        else $error("invalidate bit readback wrong");
    inv_start_a: assert property ( // R12
        $rose(busStall)
        |-> $past(ctrlWrite && ctrlWdata[icc_pkg::InvalidateAllBit]))
        else $error("invalidation began without request");
    inv_end_a: assert property ( // R13
        $fell(busStall) |-> $past(q.invSet) == icc_pkg::LastSet)
        else $error("invalidation ended early");
    fb_load_a: assert property ( // R3
        fillDone && q.fbPend && !fillStart && !q.busy
        |=> q.fbValid && q.fbLine == $past(q.pendLine))
        else $error("fill buffer not loaded");
    half_pick_a: assert property ( // R8
        allocReq && !q.busy && halfLock && setValid[2] && setValid[3]
        |=> allocWay == ($past(q.rr[1]) ? 2'h3 : 2'h2))
        else $error("half-lock pick wrong");
    lock_keep_a: assert property ( // R9
        allocReq && !q.busy && halfLock && !pushReq
        |=> q.valid[$past(allocSet)][1:0] == $past(q.valid[allocSet][1:0]))
        else $error("locked ways changed by allocation");
    push_keep_a: assert property ( // R6
        pushReq && !q.busy && q.ctrl[icc_pkg::PushInvDisableBit]
        && q.valid[pushSet][pushWay]
        |=> q.valid[$past(pushSet)][$past(pushWay)])
        else $error("push cleared a kept line");
    mode_a: assert property ( // R11
        fetchReq && !q.busy && !regionHit
        |=> fetchInhib == $past(q.ctrl[icc_pkg::DefaultModeBit]))
        else $error("default fetch mode ignored");
endmodule : icc_control
`default_nettype wire

// File: icc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module icc_far_model (
    input  wire logic        clk_sys,   // core clock
    output logic             fillStart, // burst begins
    output logic      [27:0] fillLine,  // burst line
    output logic             fillInhib, // burst inhibited
    output logic      [1:0]  fillTt,    // burst transfer_type
    output logic             fillDone   // burst ends
);
    initial {fillStart, fillLine, fillInhib, fillTt, fillDone} = '0;
    // burst line fill, line released after start
    task automatic burst(logic [27:0] l, logic i, logic [1:0] t);
        @(negedge clk_sys);
        {fillStart, fillLine, fillInhib, fillTt} = {1'b1, l, i, t};
        @(negedge clk_sys);
        {fillStart, fillLine, fillInhib, fillTt} = {1'b0, ~l, ~i, ~t};
        repeat (3) @(negedge clk_sys);
        fillDone = 1'b1;
        @(negedge clk_sys);
        fillDone = 1'b0;
    endtask : burst
endmodule : icc_far_model
`default_nettype wire

// File: icc_pkg.sv
// Operation
// R1: buffer disabled keeps no inhibited fetches
// R2: buffer only for inhibited type-0 reads
// R3: buffer loaded by burst, hits skip bus
// R4: buffer dropped on invalidate, burst, fill; code still loads it when a fill ends in the same cycle as the invalidate write
// R5: writes never touch buffer contents
// R6: line push invalidates unless disable set
// R7: normal: lowest invalid, else round-robin mod4
// R8: half-lock: ways 2/3, counter high bit
// R9: ways 0,1 not allocated while half-locked
// R10: half-lock acts immediately when changed
// R11: unmapped fetches use default mode bit
// R12: writing invalidate_all 1 clears sets sequentially
// R13: bus stalls; invalidate bit self-clears
// R14: reset leaves valid bits untouched
// R15: software pushes lines before invalidating
// R16: software writes reserved bits as zero
// R17: cache disable preserves contents
// R18: reset clears control word only; code also clears fill buffer and round-robin counter
// R19: invalidate bit reads 1 while busy
`default_nettype none
package icc_pkg;
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int          CacheEnableBit    = 15;
    localparam int          FillBufEnableBit  = 13;
    localparam int          PushInvDisableBit = 12;
    localparam int          HalfLockBit       = 11;
    localparam int          DefaultModeBit    = 10;
    localparam int          InvalidateAllBit  = 8;
    localparam logic [31:0] CtrlReset         = 32'h0000_0000;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int          NumWays           = 4;
    localparam int          NumSets           = 256;
    localparam int          SetBits           = 8;
    localparam int          LineBits          = 28;
    localparam logic [1:0]  NormalTt          = 2'h0;
    localparam logic [7:0]  LastSet           = 8'hff;
endpackage : icc_pkg
`default_nettype wire
